// ### verilog/dma_engine.sv
/*
 Sixteen-channel background transfer engine with request routing, parity
 protected control storage, four protection regions and a 64-bit master.
 Assumes a memory bus that answers reads with rvalid and writes with wack.
*/
`timescale 1ns/1ps
`include "dma_cfg.svh"
module dma_engine (
   // Clock, reset, enable
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   // Requests
   input wire logic [31:0] HW_REQ_IN,
   input wire logic [15:0] SW_REQ_IN,
   input wire logic [15:0] CH_ENABLE_IN,
   // Request assignment write
   input wire logic ASSIGN_WE_IN,
   input wire logic [3:0] ASSIGN_CH_IN,
   input wire logic [4:0] ASSIGN_LINE_IN,
   // Control storage write
   input wire logic CTRL_WE_IN,
   input wire logic [3:0] CTRL_CH_IN,
   input wire logic [31:0] CTRL_SRC_IN,
   input wire logic [31:0] CTRL_DST_IN,
   input wire logic [15:0] CTRL_COUNT_IN,
   input wire logic [1:0] CTRL_ESIZE_IN,
   input wire logic [1:0] CTRL_SMODE_IN,
   input wire logic [1:0] CTRL_DMODE_IN,
   input wire logic [15:0] CTRL_SOFS_IN,
   input wire logic [15:0] CTRL_DOFS_IN,
   // Protection regions
   input wire logic [3:0] REGION_EN_IN,
   input wire logic [3:0] REGION_WR_OK_IN,
   input wire logic [3:0] REGION_RD_OK_IN,
   input wire logic [127:0] REGION_START_IN,
   input wire logic [127:0] REGION_END_IN,
   // Memory master
   output logic MEM_RREQ_OUT,
   output logic MEM_WREQ_OUT,
   output logic [31:0] MEM_ADDR_OUT,
   output logic [63:0] MEM_WDATA_OUT,
   output logic [7:0] MEM_BE_OUT,
   input wire logic MEM_GNT_IN,
   input wire logic MEM_RVALID_IN,
   input wire logic [63:0] MEM_RDATA_IN,
   input wire logic MEM_WACK_IN,
   // Status
   output logic BUSY_OUT,
   output logic [3:0] ACTIVE_CH_OUT,
   output logic [15:0] DONE_OUT,
   output logic PARITY_ERR_OUT,
   output logic PROT_ERR_OUT
);
   typedef enum logic [2:0] {
      IDLE, LOAD, RD, RD_WAIT, WR, WR_WAIT, DONE
   } st_e;
   localparam int CW = 32 + 32 + 16 + 2 + 2 + 2 + 16 + 16;
   st_e st_r;
   // Per-channel storage, with parity bit on top
   logic [CW:0] ctrl_mem [`DMA_CHANNELS];
   logic [4:0] assign_r [`DMA_CHANNELS];
   logic [15:0] pend_r;
   logic [31:0] hw_s1_r;
   logic [31:0] hw_s2_r;
   logic [31:0] hw_s3_r;
   logic [31:0] hw_prev_r;
   logic [31:0] hw_edge;
   logic [15:0] req_map;
   logic [15:0] ready_ch;
   logic [3:0] win_ch;
   logic win_any;
   logic [3:0] ch_r;
   logic [31:0] src_r;
   logic [31:0] dst_r;
   logic [15:0] cnt_r;
   dma_pkg::elem_size_e esz_r;
   dma_pkg::addr_mode_e sm_r;
   dma_pkg::addr_mode_e dm_r;
   logic [15:0] sofs_r;
   logic [15:0] dofs_r;
   logic [CW:0] entry;
   logic [15:0] done_r;
   logic par_err_r;
   logic prot_err_r;
   logic rd_block;
   logic wr_block;
   dma_fifo_if fif ();

   // Next address after one element
   function automatic logic [31:0] step(input logic [31:0] a,
         input dma_pkg::addr_mode_e m, input dma_pkg::elem_size_e s,
         input logic [15:0] ofs);
      logic [31:0] r;
      r = a;
      unique case (m)
         dma_pkg::ADDR_FIXED: r = a;
         dma_pkg::ADDR_INC: r = a + (32'h1 << s);
         dma_pkg::ADDR_OFFSET: r = a + {16'h0, ofs};
         dma_pkg::ADDR_RSVD: r = a;
      endcase
      return r;
   endfunction

   // Byte lanes of one element in the 64-bit beat
   function automatic logic [7:0] lanes(input logic [31:0] a,
         input dma_pkg::elem_size_e s);
      logic [7:0] r;
      r = 8'h00;
      unique case (s)
         dma_pkg::ELEM_8: r = 8'h01 << a[2:0];
         dma_pkg::ELEM_16: r = 8'h03 << {a[2:1], 1'b0};
         dma_pkg::ELEM_32: r = 8'h0f << {a[2], 2'h0};
         dma_pkg::ELEM_64: r = 8'hff;
      endcase
      return r;
   endfunction

   // Outside every enabled region an access is allowed
   function automatic logic allowed(input logic [31:0] a, input logic wr,
         input logic [3:0] en, input logic [3:0] wok, input logic [3:0] rok,
         input logic [127:0] lo, input logic [127:0] hi);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < `DMA_REGIONS; i++) begin
         if (en[i] && a >= lo[i*32 +: 32] && a <= hi[i*32 +: 32]) begin
            ok = ok && (wr ? wok[i] : rok[i]);
         end
      end
      return ok;
   endfunction

   dma_fifo #(.WIDTH(`DMA_DATA_W), .DEPTH(`DMA_FIFO_DEPTH)) u_fifo (
      .clk(CLK_IN),
      .rst(RST_IN),
      .ce(CE_IN),
      .port(fif)
   );

   // Request lines from peripherals, three-stage sync then rising edge
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         hw_s1_r <= '0;
         hw_s2_r <= '0;
         hw_s3_r <= '0;
         hw_prev_r <= '0;
      end else if (CE_IN) begin
         hw_s1_r <= HW_REQ_IN;
         hw_s2_r <= hw_s1_r;
         hw_s3_r <= hw_s2_r;
         if (hw_s2_r == hw_s3_r) begin
            hw_prev_r <= hw_s3_r;
         end
      end
   end
   assign hw_edge = (hw_s2_r == hw_s3_r) ? (hw_s3_r & ~hw_prev_r) : '0;

   // Assignment registers
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         for (int i = 0; i < `DMA_CHANNELS; i++) begin
            assign_r[i] <= 5'(i);
         end
      end else if (CE_IN && ASSIGN_WE_IN) begin
         assign_r[ASSIGN_CH_IN] <= ASSIGN_LINE_IN;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `DMA_CHANNELS; g++) begin : g_map
         // Request line 0/1 serving serial transmit/receive is just routing
         assign req_map[g] = hw_edge[assign_r[g]];
      end
   endgenerate

   // Pending flags; a new request wins over the clear on service
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         pend_r <= '0;
      end else if (CE_IN) begin
         for (int i = 0; i < `DMA_CHANNELS; i++) begin
            if ((req_map[i] || SW_REQ_IN[i]) && CH_ENABLE_IN[i]) begin
               pend_r[i] <= 1'b1;
            end else if (st_r == LOAD && ch_r == 4'(i)) begin
               pend_r[i] <= 1'b0;
            end else if (!CH_ENABLE_IN[i]) begin
               pend_r[i] <= 1'b0;
            end
         end
      end
   end

   assign ready_ch = pend_r & CH_ENABLE_IN;
   always_comb begin
      win_ch = 4'h0;
      win_any = 1'b0;
      for (int i = `DMA_CHANNELS-1; i >= 0; i--) begin
         if (ready_ch[i]) begin
            win_ch = 4'(i);
            win_any = 1'b1;
         end
      end
   end

   // Control storage with even parity
   always_ff @(posedge CLK_IN) begin
      if (CE_IN && CTRL_WE_IN) begin
         ctrl_mem[CTRL_CH_IN] <= {^{CTRL_SRC_IN, CTRL_DST_IN, CTRL_COUNT_IN,
            CTRL_ESIZE_IN, CTRL_SMODE_IN, CTRL_DMODE_IN, CTRL_SOFS_IN,
            CTRL_DOFS_IN}, CTRL_SRC_IN, CTRL_DST_IN, CTRL_COUNT_IN,
            CTRL_ESIZE_IN, CTRL_SMODE_IN, CTRL_DMODE_IN, CTRL_SOFS_IN,
            CTRL_DOFS_IN};
      end
   end
   assign entry = ctrl_mem[ch_r];

   // Transfer sequencer
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         st_r <= IDLE;
         ch_r <= '0;
         src_r <= '0;
         dst_r <= '0;
         cnt_r <= '0;
         esz_r <= dma_pkg::ELEM_8;
         sm_r <= dma_pkg::ADDR_FIXED;
         dm_r <= dma_pkg::ADDR_FIXED;
         sofs_r <= '0;
         dofs_r <= '0;
      end else if (CE_IN) begin
         unique case (st_r)
            IDLE: begin
               if (win_any) begin
                  ch_r <= win_ch;
                  st_r <= LOAD;
               end
            end
            LOAD: begin
               {src_r, dst_r, cnt_r} <= entry[CW-1 -: 80];
               esz_r <= dma_pkg::elem_size_e'(entry[37:36]);
               sm_r <= dma_pkg::addr_mode_e'(entry[35:34]);
               dm_r <= dma_pkg::addr_mode_e'(entry[33:32]);
               sofs_r <= entry[31:16];
               dofs_r <= entry[15:0];
               // Parity fault or empty count skips the bus entirely
               st_r <= (^entry || entry[CW-65 -: 16] == '0) ? DONE : RD;
            end
            RD: begin
               if (!allowed(src_r, 1'b0, REGION_EN_IN, REGION_WR_OK_IN,
                     REGION_RD_OK_IN, REGION_START_IN, REGION_END_IN)) begin
                  st_r <= DONE;
               end else if (MEM_GNT_IN && fif.wready) begin
                  st_r <= RD_WAIT;
               end
            end
            RD_WAIT: begin
               if (MEM_RVALID_IN) begin
                  src_r <= step(src_r, sm_r, esz_r, sofs_r);
                  st_r <= WR;
               end
            end
            WR: begin
               if (!allowed(dst_r, 1'b1, REGION_EN_IN, REGION_WR_OK_IN,
                     REGION_RD_OK_IN, REGION_START_IN, REGION_END_IN)) begin
                  st_r <= DONE;
               end else if (MEM_GNT_IN && fif.rvalid) begin
                  st_r <= WR_WAIT;
               end
            end
            WR_WAIT: begin
               if (MEM_WACK_IN) begin
                  dst_r <= step(dst_r, dm_r, esz_r, dofs_r);
                  cnt_r <= cnt_r - 16'h1;
                  st_r <= (cnt_r == 16'h1) ? DONE : RD;
               end
            end
            DONE: st_r <= IDLE;
         endcase
      end
   end

   // Status flags
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         done_r <= '0;
         par_err_r <= 1'b0;
         prot_err_r <= 1'b0;
      end else if (CE_IN) begin
         done_r <= '0;
         if (st_r == DONE) begin
            done_r[ch_r] <= 1'b1;
         end
         if (st_r == LOAD && ^entry) begin
            par_err_r <= 1'b1;
         end
         if ((st_r == RD && !allowed(src_r, 1'b0, REGION_EN_IN, REGION_WR_OK_IN,
               REGION_RD_OK_IN, REGION_START_IN, REGION_END_IN)) ||
               (st_r == WR && !allowed(dst_r, 1'b1, REGION_EN_IN,
               REGION_WR_OK_IN, REGION_RD_OK_IN, REGION_START_IN,
               REGION_END_IN))) begin
            prot_err_r <= 1'b1;
         end
      end
   end

   // Memory master outputs registered from state
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         MEM_RREQ_OUT <= 1'b0;
         MEM_WREQ_OUT <= 1'b0;
         MEM_ADDR_OUT <= '0;
         MEM_WDATA_OUT <= '0;
         MEM_BE_OUT <= '0;
      end else if (CE_IN) begin
         // Request rises with the grant and stands until the answer arrives
         MEM_RREQ_OUT <= (st_r == RD && !rd_block && MEM_GNT_IN && fif.wready) ||
            (st_r == RD_WAIT && !MEM_RVALID_IN);
         MEM_WREQ_OUT <= (st_r == WR && !wr_block && MEM_GNT_IN && fif.rvalid) ||
            (st_r == WR_WAIT && !MEM_WACK_IN);
         MEM_ADDR_OUT <= (st_r == WR || st_r == WR_WAIT) ? dst_r : src_r;
         MEM_BE_OUT <= lanes((st_r == WR || st_r == WR_WAIT) ? dst_r : src_r, esz_r);
         MEM_WDATA_OUT <= fif.rdata;
      end
   end

   assign fif.wdata = MEM_RDATA_IN;
   assign fif.wvalid = (st_r == RD_WAIT) && MEM_RVALID_IN && CE_IN;
   // A refused write still holds its element; dropping it keeps stale data
   // out of the next transfer
   assign fif.rready = ((st_r == WR_WAIT && MEM_WACK_IN) || wr_block) && CE_IN;

   // Region checks for the access about to be issued
   assign rd_block = (st_r == RD) && !allowed(src_r, 1'b0, REGION_EN_IN, REGION_WR_OK_IN,
      REGION_RD_OK_IN, REGION_START_IN, REGION_END_IN);
   assign wr_block = (st_r == WR) && !allowed(dst_r, 1'b1, REGION_EN_IN, REGION_WR_OK_IN,
      REGION_RD_OK_IN, REGION_START_IN, REGION_END_IN);

   assign BUSY_OUT = (st_r != IDLE);
   assign ACTIVE_CH_OUT = ch_r;
   assign DONE_OUT = done_r;
   assign PARITY_ERR_OUT = par_err_r;
   assign PROT_ERR_OUT = prot_err_r;
endmodule

// ### verilog/dma_cfg.svh
/*
 Channel, line and region counts, widths, FIFO depth and mode codes for the transfer engine.
 Assumes inclusion by bare name from the engine's design files.
*/
// Function
// - Copies data between any two memory locations without processor help.
// - Sixteen channels, each with its own enable bit.
// - Thirty-two hardware request lines from peripherals trigger channels.
// - Per-channel assignment registers pick the triggering request line.
// - After reset channel n is served by request line n.
// - Transfers start by hardware request or software request.
// - One 64-bit bus master port reaches the memory system.
// - Data in flight sits in a four-entry, 64-bit FIFO.
// - Element width is 8, 16, 32 or 64 bits per transaction.
// - Addresses stay fixed, step by element size, or step by offset.
// - Channel control storage carries parity; bad entries are flagged on read.
// - Accesses are checked against four protection regions; violations are blocked.
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH
`define DMA_CHANNELS 16
`define DMA_REQ_LINES 32
`define DMA_DATA_W 64
`define DMA_ADDR_W 32
`define DMA_FIFO_DEPTH 4
`define DMA_CNT_W 16
`define DMA_MODE_FIXED 2'h0
`define DMA_MODE_INC 2'h1
`define DMA_MODE_OFFSET 2'h2
`define DMA_REGIONS 4
`endif

// ### verilog/dma_pkg.sv
/*
 Types shared by the transfer engine's modules.
 Assumes the config header is compiled alongside.
*/
package dma_pkg;
   typedef enum logic [1:0] {
      ELEM_8,
      ELEM_16,
      ELEM_32,
      ELEM_64
   } elem_size_e;
   typedef enum logic [1:0] {
      ADDR_FIXED,
      ADDR_INC,
      ADDR_OFFSET,
      ADDR_RSVD
   } addr_mode_e;
endpackage

// ### verilog/dma_fifo_if.sv
/*
 Valid/ready carrier between the engine and its data FIFO.
 Assumes one clock for both sides.
*/
`timescale 1ns/1ps
interface dma_fifo_if;
   logic [63:0] wdata;
   logic wvalid;
   logic wready;
   logic [63:0] rdata;
   logic rvalid;
   logic rready;
   modport fifo (input wdata, input wvalid, output wready,
      output rdata, output rvalid, input rready);
   modport user (output wdata, output wvalid, input wready,
      input rdata, input rvalid, output rready);
endinterface

// ### verilog/dma_fifo.sv
/*
 Parameterised synchronous FIFO with valid/ready on both sides.
 Assumes one clock, synchronous active-high reset and a clock enable.
*/
`timescale 1ns/1ps
module dma_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   dma_fifo_if.fifo port
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign port.wready = (cnt_r != (AW+1)'(DEPTH));
   assign port.rvalid = (cnt_r != '0);
   assign port.rdata = mem[rp_r];
   assign push = port.wvalid && port.wready;
   assign pop = port.rvalid && port.rready;
   always_ff @(posedge clk) begin
      if (ce && push) begin
         mem[wp_r] <= port.wdata;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (ce) begin
         if (push) begin
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// ### testbench/dma_engine_chk.sv
/*
 Concurrent checks on the transfer engine's top-level ports.
 Assumes binding to dma_engine and a memory side that always grants.
*/
`timescale 1ns/1ps
module dma_engine_chk (
   // Clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // Memory master
   input wire logic MEM_RREQ_OUT,
   input wire logic MEM_WREQ_OUT,
   input wire logic [31:0] MEM_ADDR_OUT,
   input wire logic [63:0] MEM_WDATA_OUT,
   input wire logic MEM_RVALID_IN,
   // Status
   input wire logic BUSY_OUT,
   input wire logic [15:0] DONE_OUT,
   input wire logic PARITY_ERR_OUT,
   input wire logic PROT_ERR_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   sequence rd_start_s;
      $rose(MEM_RREQ_OUT);
   endsequence
   sequence rd_to_wr_s;
      ##[1:40] MEM_RVALID_IN ##[1:40] (MEM_WREQ_OUT || PROT_ERR_OUT);
   endsequence
   done_onehot_a: assert property ($onehot0(DONE_OUT))
      else $error("two channels finished together");
   req_excl_a: assert property (!(MEM_RREQ_OUT && MEM_WREQ_OUT))
      else $error("read and write requested together");
   req_busy_a: assert property ((MEM_RREQ_OUT || MEM_WREQ_OUT) |-> BUSY_OUT)
      else $error("bus request while idle");
   done_quiet_a: assert property (|DONE_OUT |-> !MEM_RREQ_OUT && !MEM_WREQ_OUT)
      else $error("bus request during completion");
   read_then_write_a: assert property (rd_start_s |-> rd_to_wr_s)
      else $error("read not followed by its write");
   write_hold_a: assert property (MEM_WREQ_OUT && $past(MEM_WREQ_OUT) |->
      $stable(MEM_WDATA_OUT) && $stable(MEM_ADDR_OUT)) else $error("write request changed");
   read_hold_a: assert property (MEM_RREQ_OUT && $past(MEM_RREQ_OUT) |->
      $stable(MEM_ADDR_OUT)) else $error("read request changed");
   prot_sticky_a: assert property (PROT_ERR_OUT |=> PROT_ERR_OUT)
      else $error("protection flag dropped");
   parity_sticky_a: assert property (PARITY_ERR_OUT |=> PARITY_ERR_OUT)
      else $error("parity flag dropped");
   prot_done_a: assert property ($rose(PROT_ERR_OUT) |-> ##[0:8] (|DONE_OUT))
      else $error("blocked transfer not completed");
endmodule
bind dma_engine dma_engine_chk i_dma_engine_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
   .MEM_RREQ_OUT(MEM_RREQ_OUT), .MEM_WREQ_OUT(MEM_WREQ_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
   .MEM_WDATA_OUT(MEM_WDATA_OUT), .MEM_RVALID_IN(MEM_RVALID_IN), .BUSY_OUT(BUSY_OUT),
   .DONE_OUT(DONE_OUT), .PARITY_ERR_OUT(PARITY_ERR_OUT), .PROT_ERR_OUT(PROT_ERR_OUT));

// ### testbench/dma_mem_model.sv
/*
 Memory system model answering the engine's 64-bit master port.
 Assumes one request at a time, each seen as a rising request level.
*/
`timescale 1ns/1ps
module dma_mem_model (
   // Clock, reset, pace
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic slow_in,
   // Requests from the engine
   input wire logic rreq_in,
   input wire logic wreq_in,
   input wire logic [31:0] addr_in,
   input wire logic [63:0] wdata_in,
   input wire logic [7:0] be_in,
   // Answers
   output logic gnt_out,
   output logic rvalid_out,
   output logic [63:0] rdata_out,
   output logic wack_out
);
   logic [63:0] mem [0:255];
   logic rreq_r, wreq_r, rd_r, wr_r;
   logic [3:0] wait_r;
   logic [7:0] idx_r;
   assign gnt_out = 1'b1;
   always @(posedge clk_in) begin
      rreq_r <= rreq_in;
      wreq_r <= wreq_in;
      rvalid_out <= 1'b0;
      wack_out <= 1'b0;
      // Idle data bus toggles so stale data never looks valid
      rdata_out <= ~rdata_out;
      if (rst_in) begin
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         rdata_out <= 64'h0;
      end else if (rd_r || wr_r) begin
         if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
         end else begin
            rvalid_out <= rd_r;
            wack_out <= wr_r;
            if (rd_r) begin
               rdata_out <= mem[idx_r];
            end
            rd_r <= 1'b0;
            wr_r <= 1'b0;
         end
      end else if (rreq_in && !rreq_r) begin
         rd_r <= 1'b1;
         idx_r <= addr_in[10:3];
         wait_r <= slow_in ? 4'h5 : 4'h0;
      end else if (wreq_in && !wreq_r) begin
         wr_r <= 1'b1;
         wait_r <= slow_in ? 4'h5 : 4'h0;
         for (int b = 0; b < 8; b++) begin
            if (be_in[b]) begin
               mem[addr_in[10:3]][b*8 +: 8] <= wdata_in[b*8 +: 8];
            end
         end
      end
   end
endmodule

// ### testbench/tb_dma_channel_request_engine.sv
/*
 Self-checking bench for the transfer engine and its data FIFO.
 Assumes the memory model answers every request of the engine.
*/
`timescale 1ns/1ps
module tb_dma_channel_request_engine;
   logic CLK_IN, RST_IN, CE_IN, ASSIGN_WE_IN, CTRL_WE_IN, MEM_GNT_IN, MEM_RVALID_IN;
   logic MEM_WACK_IN, MEM_RREQ_OUT, MEM_WREQ_OUT, BUSY_OUT, PARITY_ERR_OUT, PROT_ERR_OUT;
   logic [31:0] HW_REQ_IN, CTRL_SRC_IN, CTRL_DST_IN, MEM_ADDR_OUT;
   logic [15:0] SW_REQ_IN, CH_ENABLE_IN, CTRL_COUNT_IN, CTRL_SOFS_IN, CTRL_DOFS_IN;
   logic [15:0] DONE_OUT, seen;
   logic [3:0] ASSIGN_CH_IN, CTRL_CH_IN, REGION_EN_IN, REGION_WR_OK_IN, REGION_RD_OK_IN;
   logic [3:0] ACTIVE_CH_OUT;
   logic [4:0] ASSIGN_LINE_IN;
   logic [1:0] CTRL_ESIZE_IN, CTRL_SMODE_IN, CTRL_DMODE_IN;
   logic [127:0] REGION_START_IN, REGION_END_IN;
   logic [63:0] MEM_WDATA_OUT, MEM_RDATA_IN;
   logic [7:0] MEM_BE_OUT;
   logic slow;
   int error_cnt, checks;
   dma_engine i_dma_engine (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN),
      .HW_REQ_IN(HW_REQ_IN), .SW_REQ_IN(SW_REQ_IN), .CH_ENABLE_IN(CH_ENABLE_IN),
      .ASSIGN_WE_IN(ASSIGN_WE_IN), .ASSIGN_CH_IN(ASSIGN_CH_IN), .ASSIGN_LINE_IN(ASSIGN_LINE_IN),
      .CTRL_WE_IN(CTRL_WE_IN), .CTRL_CH_IN(CTRL_CH_IN), .CTRL_SRC_IN(CTRL_SRC_IN),
      .CTRL_DST_IN(CTRL_DST_IN), .CTRL_COUNT_IN(CTRL_COUNT_IN), .CTRL_ESIZE_IN(CTRL_ESIZE_IN),
      .CTRL_SMODE_IN(CTRL_SMODE_IN), .CTRL_DMODE_IN(CTRL_DMODE_IN),
      .CTRL_SOFS_IN(CTRL_SOFS_IN), .CTRL_DOFS_IN(CTRL_DOFS_IN), .REGION_EN_IN(REGION_EN_IN),
      .REGION_WR_OK_IN(REGION_WR_OK_IN), .REGION_RD_OK_IN(REGION_RD_OK_IN),
      .REGION_START_IN(REGION_START_IN), .REGION_END_IN(REGION_END_IN),
      .MEM_RREQ_OUT(MEM_RREQ_OUT), .MEM_WREQ_OUT(MEM_WREQ_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
      .MEM_WDATA_OUT(MEM_WDATA_OUT), .MEM_BE_OUT(MEM_BE_OUT), .MEM_GNT_IN(MEM_GNT_IN),
      .MEM_RVALID_IN(MEM_RVALID_IN), .MEM_RDATA_IN(MEM_RDATA_IN), .MEM_WACK_IN(MEM_WACK_IN),
      .BUSY_OUT(BUSY_OUT), .ACTIVE_CH_OUT(ACTIVE_CH_OUT), .DONE_OUT(DONE_OUT),
      .PARITY_ERR_OUT(PARITY_ERR_OUT), .PROT_ERR_OUT(PROT_ERR_OUT));
   dma_mem_model i_dma_mem_model (.clk_in(CLK_IN), .rst_in(RST_IN), .slow_in(slow),
      .rreq_in(MEM_RREQ_OUT), .wreq_in(MEM_WREQ_OUT), .addr_in(MEM_ADDR_OUT),
      .wdata_in(MEM_WDATA_OUT), .be_in(MEM_BE_OUT), .gnt_out(MEM_GNT_IN),
      .rvalid_out(MEM_RVALID_IN), .rdata_out(MEM_RDATA_IN), .wack_out(MEM_WACK_IN));
   initial begin
      CLK_IN = 1'b0;
      forever #2.5 CLK_IN = ~CLK_IN;
   end
   function automatic logic [63:0] pat(int i);
      return {8{i[7:0]}} ^ 64'hf0e1d2c3b4a59687;
   endfunction
   task automatic tick();
      @(posedge CLK_IN);
      #1;
   endtask
   task automatic cmp_v(string n, logic [63:0] e, logic [63:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wait_done(int ch);
      for (int i = 0; i < 300; i++) begin
         tick();
         seen = seen | DONE_OUT;
         if (DONE_OUT[ch] === 1'b1) return;
      end
      error_cnt++;
      $display("CHECK FAILED done of channel %0d expected 1 seen 0", ch);
      close_out();
   endtask
   task automatic set_ctrl(int ch, int s, int d, int n, int es, int sm, int dm, int dofs);
      CTRL_WE_IN = 1'b1;
      CTRL_CH_IN = 4'(ch);
      CTRL_SRC_IN = 32'(s);
      CTRL_DST_IN = 32'(d);
      CTRL_COUNT_IN = 16'(n);
      CTRL_ESIZE_IN = 2'(es);
      CTRL_SMODE_IN = 2'(sm);
      CTRL_DMODE_IN = 2'(dm);
      CTRL_DOFS_IN = 16'(dofs);
      tick();
      CTRL_WE_IN = 1'b0;
      tick();
   endtask
   task automatic sw_go(logic [15:0] m);
      SW_REQ_IN = m;
      tick();
      SW_REQ_IN = 16'h0;
   endtask
   // One source on a request line at a time
   task automatic hw_go(int line);
      HW_REQ_IN[line] = 1'b1;
      repeat (4) tick();
      HW_REQ_IN[line] = 1'b0;
   endtask
   task automatic t_copy();
      set_ctrl(3, 32'h100, 32'h200, 2, 3, 1, 1, 0);
      hw_go(3);
      wait_done(3);
      cmp_v("copy word 0", pat(8'h20), i_dma_mem_model.mem[8'h40]);
      cmp_v("copy word 1", pat(8'h21), i_dma_mem_model.mem[8'h41]);
   endtask
   task automatic t_remap();
      ASSIGN_WE_IN = 1'b1;
      ASSIGN_CH_IN = 4'h5;
      ASSIGN_LINE_IN = 5'h14;
      tick();
      ASSIGN_WE_IN = 1'b0;
      set_ctrl(5, 32'h108, 32'h210, 1, 3, 1, 1, 0);
      seen = 16'h0;
      hw_go(5);
      repeat (20) begin
         tick();
         seen = seen | DONE_OUT;
      end
      cmp_v("old line ignored", 64'h0, {48'h0, seen});
      hw_go(20);
      wait_done(5);
      cmp_v("remapped copy", pat(8'h21), i_dma_mem_model.mem[8'h42]);
   endtask
   task automatic t_sizes();
      logic [63:0] m;
      slow = 1'b1;
      for (int s = 0; s < 4; s++) begin
         set_ctrl(8, 32'h300, 32'h400 + 8 * s, 1, s, 1, 1, 0);
         sw_go(16'h0100);
         wait_done(8);
         m = (s == 3) ? '1 : ((64'h1 << (8 << s)) - 64'h1);
         cmp_v("sized element", (pat(8'h80 + s) & ~m) | (pat(8'h60) & m),
            i_dma_mem_model.mem[8'h80 + s]);
      end
      slow = 1'b0;
   endtask
   task automatic t_modes();
      set_ctrl(9, 32'h500, 32'h580, 3, 3, 0, 2, 16);
      sw_go(16'h0200);
      wait_done(9);
      for (int k = 0; k < 3; k++) begin
         cmp_v("offset dest", pat(8'ha0), i_dma_mem_model.mem[8'hb0 + 2 * k]);
      end
      cmp_v("skipped word", pat(8'hb1), i_dma_mem_model.mem[8'hb1]);
   endtask
   task automatic t_prio();
      set_ctrl(1, 32'h110, 32'h700, 1, 3, 1, 1, 0);
      set_ctrl(2, 32'h118, 32'h708, 1, 3, 1, 1, 0);
      seen = 16'h0;
      sw_go(16'h0086);
      wait_done(1);
      cmp_v("first served", 64'h2, {48'h0, seen});
      cmp_v("active channel", 64'h1, {60'h0, ACTIVE_CH_OUT});
      wait_done(2);
      repeat (20) begin
         tick();
         seen = seen | DONE_OUT;
      end
      cmp_v("disabled channel idle", 64'h6, {48'h0, seen});
      cmp_v("second copy", pat(8'h23), i_dma_mem_model.mem[8'he1]);
   endtask
   task automatic t_prot();
      cmp_v("no blocking yet", 64'h0, {63'h0, PROT_ERR_OUT});
      REGION_EN_IN = 4'h3;
      set_ctrl(10, 32'h100, 32'h600, 1, 3, 1, 1, 0);
      sw_go(16'h0400);
      wait_done(10);
      repeat (2) tick();
      cmp_v("blocked flag", 64'h1, {63'h0, PROT_ERR_OUT});
      cmp_v("blocked dest", pat(8'hc0), i_dma_mem_model.mem[8'hc0]);
   endtask
   // Four elements through the engine's buffer, source stepping by offset
   task automatic t_fifo();
      slow = 1'b1;
      CTRL_SOFS_IN = 16'h10;
      set_ctrl(11, 32'h140, 32'h240, 4, 3, 2, 1, 0);
      sw_go(16'h0800);
      wait_done(11);
      for (int k = 0; k < 4; k++) begin
         cmp_v("fifo order", pat(8'h28 + 2 * k), i_dma_mem_model.mem[8'h48 + k]);
      end
      cmp_v("fifo fill", pat(8'h4c), i_dma_mem_model.mem[8'h4c]);
      repeat (2) tick();
      cmp_v("fifo drain", 64'h0, {63'h0, BUSY_OUT});
      slow = 1'b0;
   endtask
   // Serial transmit request on line 0 with an empty count
   task automatic t_zero();
      set_ctrl(0, 32'h100, 32'h280, 0, 3, 1, 1, 0);
      hw_go(0);
      wait_done(0);
      cmp_v("empty count", pat(8'h50), i_dma_mem_model.mem[8'h50]);
   endtask
   initial begin
      error_cnt = 0;
      checks = 0;
      seen = 16'h0;
      slow = 1'b0;
      CE_IN = 1'b1;
      RST_IN = 1'b1;
      {HW_REQ_IN, SW_REQ_IN, CH_ENABLE_IN, ASSIGN_WE_IN, ASSIGN_CH_IN, ASSIGN_LINE_IN} = '0;
      {CTRL_WE_IN, CTRL_CH_IN, CTRL_SRC_IN, CTRL_DST_IN, CTRL_COUNT_IN, CTRL_ESIZE_IN} = '0;
      {CTRL_SMODE_IN, CTRL_DMODE_IN, CTRL_SOFS_IN, CTRL_DOFS_IN} = '0;
      // Region 1 grants all below 0x600; region 0, off until t_prot, forbids writes to 0x600-0x6ff
      REGION_EN_IN = 4'h2;
      REGION_WR_OK_IN = 4'h2;
      REGION_RD_OK_IN = 4'h3;
      REGION_START_IN = {64'h0, 32'h0, 32'h600};
      REGION_END_IN = {64'h0, 32'h5ff, 32'h6ff};
      for (int i = 0; i < 256; i++) i_dma_mem_model.mem[i] = pat(i);
      repeat (6) @(posedge CLK_IN);
      #1;
      RST_IN = 1'b0;
      cmp_v("done after reset", 64'h0, {48'h0, DONE_OUT});
      CH_ENABLE_IN = 16'hff7f;
      t_copy();
      t_remap();
      t_sizes();
      t_modes();
      t_prio();
      t_prot();
      t_fifo();
      t_zero();
      cmp_v("parity clean", 64'h0, {63'h0, PARITY_ERR_OUT});
      cmp_v("idle at end", 64'h0, {63'h0, BUSY_OUT});
      close_out();
   end
endmodule
